/* File: design/fpr_bus_if.sv */
// Synchronised host bus events passed from the pin front end to the control core
interface fpr_bus_if;
  logic rd_stb;
  logic rd_act;
  logic wr_stb;
  logic [9:0] addr;
  logic [9:0] wr_addr;
  logic [7:0] wdata;

  modport front (output rd_stb, output rd_act, output wr_stb, output addr,
                 output wr_addr, output wdata);
  modport core (input rd_stb, input rd_act, input wr_stb, input addr,
                input wr_addr, input wdata);
endinterface

/* File: design/fpr_bus_sync.sv */
// Host pin synchroniser and strobe detector
module fpr_bus_sync
  import fpr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] data_i,
  // Towards the core
  fpr_bus_if.front bus
);

  fpr_sync_t q_ff;
  fpr_sync_t nxt_q;
  logic rd_now;
  logic wr_now;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.s1_strb = {~rd_n_i, ~wr_n_i};
    nxt_q.s2_strb = q_ff.s1_strb;
    nxt_q.s1_cs = ~cs_n_i;
    nxt_q.s2_cs = q_ff.s1_cs;
    nxt_q.s1_addr = addr_i;
    nxt_q.s2_addr = q_ff.s1_addr;
    nxt_q.s1_data = data_i;
    nxt_q.s2_data = q_ff.s1_data;
    nxt_q.s3_rd = rd_now;
    nxt_q.s3_wr = wr_now;
    // Capture while the write is active, commit on its trailing edge
    if (wr_now) begin
      nxt_q.hold_addr = q_ff.s2_addr;
      nxt_q.hold_data = q_ff.s2_data;
    end
  end

  assign rd_now = q_ff.s2_strb[1] & q_ff.s2_cs;
  assign wr_now = q_ff.s2_strb[0] & q_ff.s2_cs;
  assign bus.rd_stb = rd_now & ~q_ff.s3_rd;
  assign bus.rd_act = rd_now;
  assign bus.wr_stb = q_ff.s3_wr & ~wr_now;
  assign bus.addr = q_ff.s2_addr;
  assign bus.wr_addr = q_ff.hold_addr;
  assign bus.wdata = q_ff.hold_data;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

/* File: design/fpr_ctrl.sv */
// Data rate, write precompensation, low power and reset control of the disk controller
//
// Summary of operation
// - Configuration control register bits 1:0 select the data rate.
// - Rate select register bits 1:0 also select rate, same encoding.
// - The most recent write to either register sets the effective rate.
// - Rate scales separator clock divider; rate pins mirror last written bits.
// - Default precompensation applies until rate select register picks another.
// - Precompensation start track resets to zero; configure command changes it.
// - Low power stops oscillator, separator and all oscillator-clocked logic.
// - Entering power down clears the host request flag.
// - Software reset via output control or rate select wakes and reinitialises.
// - Data or status register access wakes, keeping all register contents but the low power bit.
// - Request flag stays 0 until oscillator stable, then 1 and resume.
// - Rate select bit 6 enters low power now; clears after wake.
// - Manual low power is rate select bit 6 OR mode command bit.
// - Auto low power enters 500 ms after idle; only mode command enables.
// - Rate, output and configuration registers stay live during power down.
// - Hardware reset restores defaults: FIFO off, threshold 0, seeks off, polling on.
// - Rate select reset bit self-clears; output control reset bit persists.
// - With lock set, software reset keeps FIFO, threshold, track, mode options.
// - Status reads 00 after reset; bit 7 reads 1 within 2.5 us of output control bit 2 being set.
// - All registers but status and data stay accessible, even in reset.
// - The host request flag is bit 7 of host status.
module fpr_ctrl
  import fpr_pkg::*;
#(
  parameter int AUTO_CYC = FPR_AUTO_CYC,
  parameter int OSC_CYC = FPR_OSC_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Host bus pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Command engine status and settings
  input wire logic idle_i,
  input wire logic [6:0] status_low_i,
  input wire logic [7:0] data_reg_i,
  input wire logic mode_man_lp_i,
  input wire logic mode_auto_lp_i,
  input wire logic cfg_load_i,
  input wire logic cfg_fifo_en_i,
  input wire logic [3:0] cfg_fifo_level_setting_i,
  input wire logic [7:0] cfg_precomp_start_track_i,
  input wire logic cfg_poll_i,
  input wire logic cfg_imp_seek_i,
  input wire logic mode_load_i,
  input wire logic mode_fwr_i,
  input wire logic mode_frd_i,
  input wire logic mode_bst_i,
  input wire logic lock_load_i,
  input wire logic lock_val_i,
  // Data register strobes towards the command engine
  output logic data_rd_o,
  output logic data_wr_o,
  output logic [7:0] data_wdata_o,
  // Rate, precompensation and power
  output logic rate_out_bit0_o,
  output logic rate_out_bit1_o,
  output logic [7:0] sep_div_o,
  output logic [2:0] precomp_sel_o,
  output logic osc_en_o,
  output logic core_run_o,
  output logic core_reset_o,
  output logic [7:0] output_control_o,
  // Retained configuration
  output logic fifo_en_o,
  output logic [3:0] fifo_level_setting_o,
  output logic [7:0] precomp_start_track_o,
  output logic fifo_write_option_o,
  output logic fifo_read_option_o,
  output logic burst_option_o,
  output logic lock_o,
  output logic implied_seek_o,
  output logic poll_en_o
);

  localparam logic [31:0] RDY_LAST = 32'(FPR_RDY_CYC - 1);
  localparam logic [31:0] AUTO_LAST = 32'(AUTO_CYC - 1);
  localparam logic [31:0] OSC_LAST = 32'(OSC_CYC - 1);

  fpr_bus_if bus ();

  fpr_bus_sync u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .cs_n_i(cs_n_i),
    .rd_n_i(rd_n_i),
    .wr_n_i(wr_n_i),
    .addr_i(addr_i),
    .data_i(data_i),
    .bus(bus)
  );

  // Divider from the master clock for a given rate code
  function automatic logic [7:0] rate_div(input logic [1:0] code);
    int kbps;
    kbps = 500;
    case (code)
      FPR_R500K: kbps = 500;
      FPR_R300K: kbps = 300;
      FPR_R250K: kbps = 250;
      FPR_R1M: kbps = 1000;
      default: kbps = 500;
    endcase
    return 8'(FPR_MASTER_KHZ / kbps);
  endfunction

  // Host ports whose access wakes the device
  function automatic logic wake_port(input logic [9:0] a);
    return a == FPR_OFS_STATUS || a == FPR_OFS_DATA;
  endfunction

  // Committed write aimed at one offset
  function automatic logic wr_hit(input logic stb, input logic [9:0] wa, input logic [9:0] a);
    return stb && wa == a;
  endfunction

  // Status and data reads show the busy value until ready
  function automatic logic [7:0] gate_busy(input logic rdy, input logic [7:0] v);
    return rdy ? v : FPR_HS_BUSY;
  endfunction

  fpr_core_t q_ff;
  fpr_core_t nxt_q;
  logic wr_rs;
  logic wr_cc;
  logic wr_oc;
  logic wr_dat;
  logic acc_wake;
  logic man_lp;
  logic sw_rst;
  logic ready;
  logic lp_req;
  logic [7:0] status_val;

  assign wr_rs = wr_hit(bus.wr_stb, bus.wr_addr, FPR_OFS_RATE_SEL);
  assign wr_cc = wr_hit(bus.wr_stb, bus.wr_addr, FPR_OFS_CFG_CTRL);
  assign wr_oc = wr_hit(bus.wr_stb, bus.wr_addr, FPR_OFS_OUT_CTRL);
  assign wr_dat = wr_hit(bus.wr_stb, bus.wr_addr, FPR_OFS_DATA);
  assign acc_wake = (bus.rd_stb && wake_port(bus.addr)) || wr_dat;
  assign man_lp = q_ff.dsr_lp | mode_man_lp_i;
  // a direct write enters even while the mode bit is held high
  assign lp_req = (man_lp && !q_ff.man_prev) || (wr_rs && bus.wdata[FPR_RS_LOWPWR]);
  // rate select pulse or held output control bit
  assign sw_rst = q_ff.swr_pls | ~q_ff.oc[FPR_OC_RESET_N];
  assign ready = (q_ff.st == FPR_ST_RUN) && !sw_rst;
  // busy value until ready; request flag in bit 7
  assign status_val = gate_busy(ready, {1'b1, status_low_i});

  always_comb begin
    nxt_q = q_ff;
    nxt_q.swr_pls = 1'b0;
    // Edge detect so a held mode bit cannot re-enter after wake
    nxt_q.man_prev = man_lp;

    // rate, output and configuration registers always writable
    if (wr_rs) begin
      nxt_q.rate = bus.wdata[FPR_RS_RATE_LSB +: 2];
      nxt_q.pcmp = bus.wdata[FPR_RS_PCMP_LSB +: 3];
      nxt_q.dsr_lp = bus.wdata[FPR_RS_LOWPWR];
      nxt_q.swr_pls = bus.wdata[FPR_RS_SWRST];
    end
    // rate from configuration control; last writer wins
    if (wr_cc) begin
      nxt_q.rate = bus.wdata[FPR_RS_RATE_LSB +: 2];
    end
    // output control reset bit held by software
    if (wr_oc) begin
      nxt_q.oc = bus.wdata;
    end

    // Command-loaded settings
    if (cfg_load_i) begin
      nxt_q.fifo_en = cfg_fifo_en_i;
      nxt_q.fifo_level_setting = cfg_fifo_level_setting_i;
      nxt_q.precomp_start_track = cfg_precomp_start_track_i;
      nxt_q.poll = cfg_poll_i;
      nxt_q.imp_seek = cfg_imp_seek_i;
    end
    if (mode_load_i) begin
      nxt_q.fifo_write_option = mode_fwr_i;
      nxt_q.fifo_read_option = mode_frd_i;
      nxt_q.burst_option = mode_bst_i;
    end
    if (lock_load_i) begin
      nxt_q.lock = lock_val_i;
    end

    // One counter times init, idle and oscillator settling
    case (q_ff.st)
      FPR_ST_INIT: begin
        if (q_ff.cnt >= RDY_LAST) begin
          nxt_q.st = FPR_ST_RUN;
          nxt_q.cnt = '0;
        end else begin
          nxt_q.cnt = q_ff.cnt + 32'h1;
        end
      end
      FPR_ST_RUN: begin
        if (lp_req) begin
          // immediate entry; request flag drops with it
          nxt_q.st = FPR_ST_LOWPWR;
          nxt_q.cnt = '0;
        end else if (mode_auto_lp_i && idle_i) begin
          if (q_ff.cnt >= AUTO_LAST) begin
            nxt_q.st = FPR_ST_LOWPWR;
            nxt_q.cnt = '0;
          end else begin
            nxt_q.cnt = q_ff.cnt + 32'h1;
          end
        end else begin
          nxt_q.cnt = '0;
        end
      end
      FPR_ST_LOWPWR: begin
        if (acc_wake) begin
          nxt_q.st = FPR_ST_WAKE;
          nxt_q.cnt = '0;
        end
      end
      FPR_ST_WAKE: begin
        if (q_ff.cnt >= OSC_LAST) begin
          nxt_q.st = FPR_ST_RUN;
          nxt_q.cnt = '0;
          // low power bit clears after wake
          nxt_q.dsr_lp = 1'b0;
        end else begin
          nxt_q.cnt = q_ff.cnt + 32'h1;
        end
      end
      default: begin
        nxt_q.st = FPR_ST_INIT;
        nxt_q.cnt = '0;
      end
    endcase

    // Placed last so a software reset overrides any state change
    // software reset wakes and reinitialises
    if (sw_rst) begin
      nxt_q.st = FPR_ST_INIT;
      nxt_q.cnt = '0;
      if (!wr_rs) begin
        nxt_q.dsr_lp = 1'b0;
      end
      nxt_q.imp_seek = 1'b0;
      nxt_q.poll = 1'b1;
      // lock keeps FIFO, threshold, track and mode options
      if (!q_ff.lock) begin
        nxt_q.fifo_en = 1'b0;
        nxt_q.fifo_level_setting = FPR_THR_RST;
        nxt_q.precomp_start_track = FPR_TRK_RST;
        nxt_q.fifo_write_option = 1'b0;
        nxt_q.fifo_read_option = 1'b0;
        nxt_q.burst_option = 1'b0;
      end
    end

    // Read data register
    if (bus.addr == FPR_OFS_STATUS) begin
      nxt_q.rdata = status_val;
    end else if (bus.addr == FPR_OFS_DATA) begin
      nxt_q.rdata = gate_busy(ready, data_reg_i);
    end else begin
      nxt_q.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff <= '0;
      q_ff.st <= FPR_ST_INIT;
      q_ff.rate <= FPR_RATE_RST;
      q_ff.pcmp <= FPR_PCMP_RST;
      q_ff.oc <= FPR_OC_RST;
      q_ff.precomp_start_track <= FPR_TRK_RST;
      q_ff.fifo_level_setting <= FPR_THR_RST;
      q_ff.poll <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Host data bus; only status/data reads are driven, other offsets read 00
  assign data_o = q_ff.rdata;
  assign data_oe_o = bus.rd_act && wake_port(bus.addr);

  // Data register strobes only when running
  assign data_rd_o = bus.rd_stb && bus.addr == FPR_OFS_DATA && ready;
  assign data_wr_o = wr_dat && ready;
  assign data_wdata_o = bus.wdata;

  // rate pins mirror stored bits; divider follows rate; code map
  assign rate_out_bit0_o = q_ff.rate[0];
  assign rate_out_bit1_o = q_ff.rate[1];
  assign sep_div_o = rate_div(q_ff.rate);
  assign precomp_sel_o = q_ff.pcmp;

  // oscillator and clocked logic off in low power
  assign osc_en_o = q_ff.st != FPR_ST_LOWPWR;
  assign core_run_o = ready;
  assign core_reset_o = sw_rst || q_ff.st == FPR_ST_INIT;
  // output control stays live in power down
  assign output_control_o = q_ff.oc;

  assign fifo_en_o = q_ff.fifo_en;
  assign fifo_level_setting_o = q_ff.fifo_level_setting;
  assign precomp_start_track_o = q_ff.precomp_start_track;
  assign fifo_write_option_o = q_ff.fifo_write_option;
  assign fifo_read_option_o = q_ff.fifo_read_option;
  assign burst_option_o = q_ff.burst_option;
  assign lock_o = q_ff.lock;
  assign implied_seek_o = q_ff.imp_seek;
  assign poll_en_o = q_ff.poll;

endmodule

/* File: design/fpr_pkg.sv */
// Constants, types and register map of the rate, power and reset control block
package fpr_pkg;

  // Register map (host address space)
  localparam logic [9:0] FPR_OFS_OUT_CTRL = 10'h002;
  localparam logic [9:0] FPR_OFS_RATE_SEL = 10'h004;
  localparam logic [9:0] FPR_OFS_STATUS = 10'h004;
  localparam logic [9:0] FPR_OFS_DATA = 10'h005;
  localparam logic [9:0] FPR_OFS_CFG_CTRL = 10'h3f7;

  // Rate select register fields
  localparam int FPR_RS_RATE_LSB = 0;
  localparam int FPR_RS_PCMP_LSB = 2;
  localparam int FPR_RS_LOWPWR = 6;
  localparam int FPR_RS_SWRST = 7;
  // Output control register: software reset, active low
  localparam int FPR_OC_RESET_N = 2;
  // Host status register request flag
  localparam int FPR_HS_REQ = 7;

  // Reset values
  localparam logic [1:0] FPR_RATE_RST = 2'h2;
  localparam logic [2:0] FPR_PCMP_RST = 3'h0;
  localparam logic [7:0] FPR_OC_RST = 8'h00;
  localparam logic [7:0] FPR_TRK_RST = 8'h00;
  localparam logic [3:0] FPR_THR_RST = 4'h0;
  localparam logic [7:0] FPR_HS_BUSY = 8'h00;

  // Rate codes
  localparam logic [1:0] FPR_R500K = 2'h0;
  localparam logic [1:0] FPR_R300K = 2'h1;
  localparam logic [1:0] FPR_R250K = 2'h2;
  localparam logic [1:0] FPR_R1M = 2'h3;

  // Timing
  localparam int FPR_CLK_KHZ = 40_000;
  localparam int FPR_RDY_NS = 2500;
  localparam int FPR_RDY_CYC = FPR_RDY_NS * FPR_CLK_KHZ / 1_000_000;
  localparam int FPR_AUTO_MS = 500;
  localparam int FPR_AUTO_CYC = FPR_AUTO_MS * FPR_CLK_KHZ;
  localparam int FPR_OSC_US = 2000;
  localparam int FPR_OSC_CYC = FPR_OSC_US * FPR_CLK_KHZ / 1000;
  localparam int FPR_MASTER_KHZ = 24_000;

  typedef enum logic [1:0] {
    FPR_ST_INIT = 2'b00,
    FPR_ST_RUN = 2'b01,
    FPR_ST_LOWPWR = 2'b10,
    FPR_ST_WAKE = 2'b11
  } fpr_state_t;

  typedef struct packed {
    logic [1:0] s1_strb;
    logic [1:0] s2_strb;
    logic s3_rd;
    logic s3_wr;
    logic s1_cs;
    logic s2_cs;
    logic [9:0] s1_addr;
    logic [9:0] s2_addr;
    logic [7:0] s1_data;
    logic [7:0] s2_data;
    logic [9:0] hold_addr;
    logic [7:0] hold_data;
  } fpr_sync_t;

  typedef struct packed {
    fpr_state_t st;
    logic [31:0] cnt;
    logic [1:0] rate;
    logic [2:0] pcmp;
    logic dsr_lp;
    logic [7:0] oc;
    logic man_prev;
    logic swr_pls;
    logic fifo_en;
    logic [3:0] fifo_level_setting;
    logic [7:0] precomp_start_track;
    logic fifo_write_option;
    logic fifo_read_option;
    logic burst_option;
    logic lock;
    logic imp_seek;
    logic poll;
    logic [7:0] rdata;
  } fpr_core_t;

endpackage

/* File: sim/fpr_ctrl_assertions.sv */
// Port checker of the rate, power and reset control block
module fpr_ctrl_assertions
  import fpr_pkg::*;
#(
  parameter int AUTO_CYC = FPR_AUTO_CYC,
  parameter int OSC_CYC = FPR_OSC_CYC
)
(
  // Clock, reset and inputs
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic idle_i,
  input wire logic mode_man_lp_i,
  input wire logic mode_auto_lp_i,
  // Watched outputs
  input wire logic data_rd_o,
  input wire logic rate_out_bit0_o,
  input wire logic rate_out_bit1_o,
  input wire logic [7:0] sep_div_o,
  input wire logic osc_en_o,
  input wire logic core_run_o,
  input wire logic core_reset_o,
  input wire logic [7:0] output_control_o,
  input wire logic fifo_en_o,
  input wire logic [3:0] fifo_level_setting_o,
  input wire logic [7:0] precomp_start_track_o,
  input wire logic implied_seek_o,
  input wire logic poll_en_o,
  input wire logic lock_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] auto_cnt_ff;
  logic [7:0] init_cnt_ff;
  logic [1:0] rate;
  logic [7:0] div_exp;
  assign rate = {rate_out_bit1_o, rate_out_bit0_o};
  assign div_exp = (rate == FPR_R500K) ? 8'h30 : (rate == FPR_R300K) ? 8'h50 :
                   (rate == FPR_R250K) ? 8'h60 : 8'h18;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      auto_cnt_ff <= '0;
      init_cnt_ff <= '0;
    end else begin
      auto_cnt_ff <= (idle_i && mode_auto_lp_i && core_run_o) ? auto_cnt_ff + 1 : '0;
      init_cnt_ff <= (core_reset_o && output_control_o[FPR_OC_RESET_N]) ? init_cnt_ff + 8'h01 : '0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rate_div_map_a: assert property ($stable(rate) [*2] |-> sep_div_o == div_exp)
    else $error("divider does not match rate pins");
  lp_core_halt_a: assert property (!osc_en_o |-> !core_run_o)
    else $error("core runs with oscillator off");
  wake_flag_low_a: assert property ($rose(osc_en_o) |-> !core_run_o [*8])
    else $error("ready before oscillator settled");
  man_lp_entry_a: assert property ($rose(mode_man_lp_i) && core_run_o |-> ##[1:4] !osc_en_o)
    else $error("manual low power not entered");
  auto_lp_bound_a: assert property (auto_cnt_ff <= AUTO_CYC + 4)
    else $error("automatic low power late");
  ready_bound_a: assert property (init_cnt_ff <= FPR_RDY_CYC + 4)
    else $error("ready not reached after reset");
  oc_reset_hold_a: assert property (!output_control_o[FPR_OC_RESET_N] |-> core_reset_o)
    else $error("output control reset bit not held");
  hw_defaults_a: assert property ($rose(resetn_i) |-> !fifo_en_o &&
    fifo_level_setting_o == 4'h0 && !implied_seek_o && poll_en_o && precomp_start_track_o == 8'h00)
    else $error("settings not at defaults after reset");
  swr_clear_a: assert property ($rose(core_reset_o) && !$past(lock_o) |-> ##[0:2] !fifo_en_o)
    else $error("fifo kept without lock");
  data_ready_a: assert property (data_rd_o |-> core_run_o)
    else $error("data read forwarded while not ready");
  cover property ($fell(osc_en_o));
  cover property ($rose(core_run_o));
  cover property ($rose(core_reset_o) && lock_o);
endmodule

bind fpr_ctrl fpr_ctrl_assertions #(.AUTO_CYC(AUTO_CYC), .OSC_CYC(OSC_CYC)) u_fpr_chk (
  .clk_i, .resetn_i, .idle_i, .mode_man_lp_i, .mode_auto_lp_i, .data_rd_o, .rate_out_bit0_o,
  .rate_out_bit1_o, .sep_div_o, .osc_en_o, .core_run_o, .core_reset_o, .output_control_o,
  .fifo_en_o, .fifo_level_setting_o, .precomp_start_track_o, .implied_seek_o, .poll_en_o,
  .lock_o);

/* File: sim/fpr_ctrl_tb_top.sv */
// Self-checking bench of the rate, power and reset control block
module fpr_ctrl_tb_top
  import fpr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int OSC = 20;
  localparam int AUTO = 50;
  localparam logic [9:0] A_OC = FPR_OFS_OUT_CTRL;
  localparam logic [9:0] A_RS = FPR_OFS_RATE_SEL;
  localparam logic [9:0] A_CC = FPR_OFS_CFG_CTRL;
  localparam logic [7:0] RDY = 8'h95;
  logic clk_i, resetn_i = 1'b0;
  logic idle_i = 1'b0, mode_man_lp_i = 1'b0, mode_auto_lp_i = 1'b0;
  logic [6:0] status_low_i = 7'h15;
  logic [7:0] data_reg_i = 8'h3c;
  logic cfg_load_i = 1'b0, cfg_fifo_en_i = 1'b0, cfg_poll_i = 1'b1, cfg_imp_seek_i = 1'b0;
  logic [3:0] cfg_fifo_level_setting_i = 4'h0;
  logic [7:0] cfg_precomp_start_track_i = 8'h00;
  logic mode_load_i = 1'b0, mode_fwr_i = 1'b0, mode_frd_i = 1'b0, mode_bst_i = 1'b0;
  logic lock_load_i = 1'b0, lock_val_i = 1'b0;
  logic cs_n, rd_n, wr_n, data_oe_o, osc_en_o, core_run_o, fifo_en_o, lock_o;
  logic rate_out_bit0_o, rate_out_bit1_o, implied_seek_o, poll_en_o;
  logic fifo_write_option_o, fifo_read_option_o, burst_option_o;
  logic [9:0] addr;
  logic [7:0] wdata, data_o, sep_div_o, output_control_o, precomp_start_track_o;
  logic [2:0] precomp_sel_o;
  logic [3:0] fifo_level_setting_o;
  int fails = 0, compares = 0, cycles = 0;
  int oe_cnt = 0, rd_cnt = 0;
  logic core_reset_o, data_rd_o, data_wr_o;
  logic [7:0] data_wdata_o, wr_byte = 8'h00;
  wire logic [7:0] opts = {fifo_write_option_o, fifo_read_option_o, burst_option_o, fifo_en_o,
                           fifo_level_setting_o};
  wire logic [7:0] pwr = {6'h00, osc_en_o, core_run_o};
  wire logic [7:0] rate = {6'h00, rate_out_bit1_o, rate_out_bit0_o};
  wire logic [7:0] seek = {6'h00, implied_seek_o, poll_en_o};

  fpr_ctrl #(.AUTO_CYC(AUTO), .OSC_CYC(OSC)) dut (
    .clk_i, .resetn_i, .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
    .data_i(wdata), .data_o, .data_oe_o, .idle_i, .status_low_i, .data_reg_i, .mode_man_lp_i,
    .mode_auto_lp_i, .cfg_load_i, .cfg_fifo_en_i, .cfg_fifo_level_setting_i, .cfg_precomp_start_track_i, .cfg_poll_i,
    .cfg_imp_seek_i, .mode_load_i, .mode_fwr_i, .mode_frd_i, .mode_bst_i, .lock_load_i,
    .lock_val_i, .data_rd_o, .data_wr_o, .data_wdata_o, .rate_out_bit0_o,
    .rate_out_bit1_o, .sep_div_o, .precomp_sel_o, .osc_en_o, .core_run_o, .core_reset_o,
    .output_control_o, .fifo_en_o, .fifo_level_setting_o, .precomp_start_track_o,
    .fifo_write_option_o, .fifo_read_option_o, .burst_option_o, .lock_o,
    .implied_seek_o, .poll_en_o);
  fpr_host_model host (.clk_i, .rdata_i(data_o), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .wdata_o(wdata));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (data_oe_o === 1'b1) begin
      oe_cnt <= oe_cnt + 1;
    end
    if (data_rd_o === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
    if (data_wr_o === 1'b1) begin
      wr_byte <= data_wdata_o;
    end
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [9:0] a, input logic [7:0] e);
    logic [7:0] d;
    int n0;
    n0 = oe_cnt;
    host.rd(a, d);
    chk(n, e, d);
    chk("read enable", 8'h01, 8'(oe_cnt > n0));
  endtask
  function automatic logic [7:0] div_of(input logic [1:0] r);
    case (r)
      FPR_R500K: return 8'h30;
      FPR_R300K: return 8'h50;
      FPR_R250K: return 8'h60;
      default: return 8'h18;
    endcase
  endfunction
  task automatic t_reset();
    chk("opts", 8'h00, opts);
    chk("seek", 8'h01, seek);
    chk("track", 8'h00, precomp_start_track_o);
    chk("precomp", {5'h00, FPR_PCMP_RST}, {5'h00, precomp_sel_o});
    chk("rate", {6'h00, FPR_RATE_RST}, rate);
    rchk("status", A_RS, 8'h00);
    host.wr(A_CC, 8'h01);
    chk("rate", 8'h01, rate);
    host.wr(A_OC, 8'h04);
    rchk("status", A_RS, 8'h00);
    repeat (FPR_RDY_CYC) @(posedge clk_i);
    rchk("status", A_RS, RDY);
  endtask
  task automatic t_rate();
    for (int i = 0; i < 4; i++) begin
      host.wr(A_RS, {3'h0, 3'(i + 1), 2'(i)});
      chk("rate", {6'h00, 2'(i)}, rate);
      chk("divider", div_of(2'(i)), sep_div_o);
      chk("precomp", {5'h00, 3'(i + 1)}, {5'h00, precomp_sel_o});
      host.wr(A_CC, {6'h00, 2'(3 - i)});
      chk("rate", {6'h00, 2'(3 - i)}, rate);
      chk("divider", div_of(2'(3 - i)), sep_div_o);
    end
  endtask
  task automatic t_man_lp();
    host.wr(A_RS, 8'h41);
    chk("power", 8'h00, pwr);
    host.wr(A_CC, 8'h03);
    chk("rate", 8'h03, rate);
    chk("power", 8'h00, pwr);
    rchk("status", A_RS, 8'h00);
    chk("power", 8'h02, pwr);
    repeat (OSC + 5) @(posedge clk_i);
    rchk("status", A_RS, RDY);
    chk("rate", 8'h03, rate);
  endtask
  task automatic t_mode_lp();
    @(posedge clk_i);
    mode_man_lp_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("power", 8'h00, pwr);
    mode_man_lp_i <= 1'b0;
    host.wr(A_RS, 8'h82);
    chk("power", 8'h02, pwr);
    rchk("status", A_RS, 8'h00);
    repeat (FPR_RDY_CYC) @(posedge clk_i);
    rchk("status", A_RS, RDY);
    chk("rate", 8'h02, rate);
  endtask
  task automatic t_auto_lp();
    @(posedge clk_i);
    idle_i <= 1'b1;
    mode_auto_lp_i <= 1'b1;
    repeat (AUTO - 10) @(posedge clk_i);
    chk("power", 8'h03, pwr);
    repeat (20) @(posedge clk_i);
    chk("power", 8'h00, pwr);
    mode_auto_lp_i <= 1'b0;
    rchk("data", FPR_OFS_DATA, 8'h00);
    chk("data reads", 8'h00, 8'(rd_cnt));
    repeat (OSC + 5) @(posedge clk_i);
    rchk("data", FPR_OFS_DATA, data_reg_i);
    chk("data reads", 8'h01, 8'(rd_cnt));
    host.wr(FPR_OFS_DATA, 8'ha7);
    chk("forwarded byte", 8'ha7, wr_byte);
    idle_i <= 1'b0;
  endtask
  task automatic t_lock();
    @(posedge clk_i);
    {cfg_fifo_en_i, cfg_fifo_level_setting_i, cfg_precomp_start_track_i, cfg_poll_i, cfg_imp_seek_i} <= 15'h4c85;
    {mode_fwr_i, mode_frd_i, mode_bst_i, lock_val_i} <= 4'hf;
    {cfg_load_i, mode_load_i, lock_load_i} <= 3'h7;
    @(posedge clk_i);
    {cfg_load_i, mode_load_i, lock_load_i} <= 3'h0;
    @(posedge clk_i);
    chk("opts", 8'hf3, opts);
    chk("lock", 8'h01, {7'h00, lock_o});
    chk("seek", 8'h02, seek);
    host.wr(A_RS, 8'h82);
    repeat (FPR_RDY_CYC) @(posedge clk_i);
    chk("opts", 8'hf3, opts);
    chk("track", 8'h21, precomp_start_track_o);
    chk("seek", 8'h01, seek);
    lock_val_i <= 1'b0;
    lock_load_i <= 1'b1;
    @(posedge clk_i);
    lock_load_i <= 1'b0;
    host.wr(A_OC, 8'h00);
    repeat (FPR_RDY_CYC + 20) @(posedge clk_i);
    chk("control", 8'h00, output_control_o);
    chk("power", 8'h02, pwr);
    chk("reset", 8'h01, {7'h00, core_reset_o});
    chk("lock", 8'h00, {7'h00, lock_o});
    chk("opts", 8'h00, opts);
    chk("track", 8'h00, precomp_start_track_o);
    host.wr(A_OC, 8'h04);
    repeat (FPR_RDY_CYC) @(posedge clk_i);
    rchk("status", A_RS, RDY);
  endtask
  task automatic final_report();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_reset();
    t_rate();
    t_man_lp();
    t_mode_lp();
    t_auto_lp();
    t_lock();
    final_report();
  end
endmodule

/* File: sim/fpr_host_model.sv */
// Host processor model driving the controller register bus pins
module fpr_host_model (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  // Bus pins
  output logic cs_n_o = 1'b1,
  output logic rd_n_o = 1'b1,
  output logic wr_n_o = 1'b1,
  output logic [9:0] addr_o = 10'h3ff,
  output logic [7:0] wdata_o = 8'h5a
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released lines show the inverse of their last value
  task automatic release_bus();
    cs_n_o <= 1'b1;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
  // whole byte held across the strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    wr_n_o <= 1'b0;
    addr_o <= a;
    wdata_o <= d;
    repeat (4) @(posedge clk_i);
    wr_n_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    release_bus();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    addr_o <= a;
    repeat (6) @(posedge clk_i);
    d = rdata_i;
    rd_n_o <= 1'b1;
    release_bus();
    repeat (3) @(posedge clk_i);
  endtask
endmodule
